// >>> verilog/cma_cfg.svh
// register offsets, field positions and reset values of the arbitration block
`ifndef CMA_CFG_SVH
`define CMA_CFG_SVH
`define CMA_ADDR_W 8
`define CMA_OFS_IF1_ARB_HIGH 8'h34
`define CMA_OFS_IF2_ARB_HIGH 8'h94
`define CMA_OFS_IF1_CTRL 8'h3C
`define CMA_OFS_IF2_CTRL 8'h9C
`define CMA_ARB_HIGH_RESET 16'h0000
`define CMA_CTRL_RESET 2'h0
`define CMA_BIT_OBJECT_VALID 15
`define CMA_BIT_EXTENDED 14
`define CMA_BIT_DIRECTION 13
`define CMA_ID_HIGH_MSB 12
`define CMA_BIT_REMOTE_ANSWER_ENABLE 0
`define CMA_BIT_TRANSMIT_REQUEST 1
`define CMA_STD_ID_LSB 18
`endif

// >>> verilog/cma_pkg.sv
// types shared by the arbitration block
package cma_pkg;
	typedef logic [28:0] cma_ident_t;
	typedef logic [15:0] cma_arb_high_t;
	typedef enum logic {
		CMA_TX_IDLE,
		CMA_TX_BUSY
	} cma_tx_state_t;
endpackage : cma_pkg

// >>> verilog/cma_top.sv
// arbitration-high registers of two interface sets and their message handling
//
// Function
// - object valid bit 15 set: handler processes object; clear: object ignored.
// - extended select bit 14 picks 29-bit identifier, else 11-bit identifier.
// - transmit direction with transmit request sends a data frame.
// - matching remote frame sets transmit request of transmit object if answer enabled.
// - receive direction with transmit request sends a remote frame.
// - matching data frame is stored into a receive-direction object.
// - bits 12..0 hold identifier bits 28..16; standard frames use 28..18.
// - bits 31..16 read as zero; software writes zero there.
// - standard objects store and filter only identifier bits 28..18.
`timescale 1ns/1ps
`include "cma_cfg.svh"

module cma_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [`CMA_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rd_data_o,
	input wire logic [15:0] if1_id_low_i,
	input wire logic [15:0] if2_id_low_i,
	input wire logic rx_valid_i,
	input wire logic rx_remote_i,
	input wire logic rx_extended_i,
	input wire cma_pkg::cma_ident_t rx_id_i,
	input wire logic tx_done_i,
	output logic [1:0] object_active_o,
	output logic [1:0] rx_store_o,
	output cma_pkg::cma_ident_t rx_store_id_o,
	output logic tx_start_o,
	output logic tx_remote_o,
	output logic tx_extended_o,
	output cma_pkg::cma_ident_t tx_id_o,
	output logic tx_busy_o
);
	import cma_pkg::*;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic cma_ident_t full_id(input cma_arb_high_t high, input logic [15:0] low);
		full_id = {high[`CMA_ID_HIGH_MSB:0], low};
	endfunction : full_id

	function automatic logic id_match(input cma_arb_high_t high, input logic [15:0] low,
		input logic ext, input cma_ident_t rid);
		cma_ident_t oid;
		oid = full_id(high, low);
		if (ext != high[`CMA_BIT_EXTENDED])
			id_match = 1'b0;
		else if (ext)
			id_match = (oid == rid);
		else
			id_match = (oid[28:`CMA_STD_ID_LSB] == rid[28:`CMA_STD_ID_LSB]);
	endfunction : id_match

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	cma_arb_high_t arb_reg [2];
	logic [1:0] rae_reg;
	logic [1:0] txrq_reg;
	logic [1:0] txrq_next;
	cma_tx_state_t state_reg;
	logic sel_reg;

	wire logic [15:0] id_low [2];
	assign id_low[0] = if1_id_low_i;
	assign id_low[1] = if2_id_low_i;

	wire logic [1:0] hit_arb;
	wire logic [1:0] hit_ctrl;
	assign hit_arb[0] = (addr_i == `CMA_OFS_IF1_ARB_HIGH);
	assign hit_arb[1] = (addr_i == `CMA_OFS_IF2_ARB_HIGH);
	assign hit_ctrl[0] = (addr_i == `CMA_OFS_IF1_CTRL);
	assign hit_ctrl[1] = (addr_i == `CMA_OFS_IF2_CTRL);

	// ------------------------------------------------------------
	// frame matching per set
	// ------------------------------------------------------------
	wire logic [1:0] valid;
	wire logic [1:0] dir_tx;
	wire logic [1:0] match;
	wire logic [1:0] store_hit;
	wire logic [1:0] remote_hit;
	wire logic [1:0] tx_ready;

	for (genvar s = 0; s < 2; s++) begin : g_set
		assign valid[s] = arb_reg[s][`CMA_BIT_OBJECT_VALID];
		assign dir_tx[s] = arb_reg[s][`CMA_BIT_DIRECTION];
		assign match[s] = rx_valid_i && valid[s] && id_match(arb_reg[s], id_low[s], rx_extended_i, rx_id_i);
		assign store_hit[s] = match[s] && !rx_remote_i && !dir_tx[s];
		assign remote_hit[s] = match[s] && rx_remote_i && dir_tx[s] && rae_reg[s];
		assign tx_ready[s] = txrq_reg[s] && valid[s];
	end

	wire logic start_now;
	wire logic start_sel;
	assign start_now = (state_reg == CMA_TX_IDLE) && (tx_ready != 2'h0);
	assign start_sel = !tx_ready[0];

	always_comb begin
		txrq_next = txrq_reg;
		for (int s = 0; s < 2; s++) begin
			if (wr_i && hit_ctrl[s])
				txrq_next[s] = wr_data_i[`CMA_BIT_TRANSMIT_REQUEST];
			if (state_reg == CMA_TX_BUSY && tx_done_i && sel_reg == s[0])
				txrq_next[s] = 1'b0;
			if (remote_hit[s])
				txrq_next[s] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			arb_reg[0] <= `CMA_ARB_HIGH_RESET;
			arb_reg[1] <= `CMA_ARB_HIGH_RESET;
			rae_reg <= `CMA_CTRL_RESET;
			txrq_reg <= `CMA_CTRL_RESET;
		end else begin
			for (int s = 0; s < 2; s++) begin
				if (wr_i && hit_arb[s])
					arb_reg[s] <= wr_data_i[15:0];
				if (wr_i && hit_ctrl[s])
					rae_reg[s] <= wr_data_i[`CMA_BIT_REMOTE_ANSWER_ENABLE];
			end
			txrq_reg <= txrq_next;
		end
	end

	wire logic [31:0] rd_mux;
	assign rd_mux = hit_arb[0] ? {16'h0000, arb_reg[0]} :
		hit_arb[1] ? {16'h0000, arb_reg[1]} :
		hit_ctrl[0] ? {30'h00000000, txrq_reg[0], rae_reg[0]} :
		hit_ctrl[1] ? {30'h00000000, txrq_reg[1], rae_reg[1]} : 32'h00000000;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			rd_data_o <= 32'h00000000;
		else if (rd_i)
			rd_data_o <= rd_mux;
		else
			rd_data_o <= 32'h00000000;
	end

	// ------------------------------------------------------------
	// receive store and transmit launch
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			object_active_o <= 2'h0;
			rx_store_o <= 2'h0;
			rx_store_id_o <= 29'h00000000;
		end else begin
			object_active_o <= valid;
			rx_store_o <= store_hit;
			if (rx_extended_i)
				rx_store_id_o <= rx_id_i;
			else
				rx_store_id_o <= {rx_id_i[28:`CMA_STD_ID_LSB], 18'h00000};
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= CMA_TX_IDLE;
			sel_reg <= 1'b0;
			tx_start_o <= 1'b0;
			tx_remote_o <= 1'b0;
			tx_extended_o <= 1'b0;
			tx_id_o <= 29'h00000000;
			tx_busy_o <= 1'b0;
		end else begin
			tx_start_o <= 1'b0;
			case (state_reg)
				CMA_TX_IDLE: begin
					if (start_now) begin
						state_reg <= CMA_TX_BUSY;
						sel_reg <= start_sel;
						tx_start_o <= 1'b1;
						tx_busy_o <= 1'b1;
						tx_remote_o <= !dir_tx[start_sel];
						tx_extended_o <= arb_reg[start_sel][`CMA_BIT_EXTENDED];
						tx_id_o <= full_id(arb_reg[start_sel], id_low[start_sel]);
					end
				end
				CMA_TX_BUSY: begin
					if (tx_done_i) begin
						state_reg <= CMA_TX_IDLE;
						tx_busy_o <= 1'b0;
					end
				end
				default: state_reg <= CMA_TX_IDLE;
			endcase
		end
	end
endmodule : cma_top

// >>> tb/cma_node_model.sv
// remote node model that finishes each launched frame
`timescale 1ns/1ps
module cma_node_model #(parameter int DELAY = 4) (
	input wire logic clk_i,
	input wire logic tx_start_i,
	output logic tx_done_o
);
	int cnt = 0;
	always @(posedge clk_i) begin
		tx_done_o <= (cnt == 1);
		if (tx_start_i)
			cnt <= DELAY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule : cma_node_model

// >>> tb/cma_top_monitor.sv
// port checker of the arbitration block
`timescale 1ns/1ps
module cma_top_monitor (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rd_data_o,
	input wire logic rx_valid_i,
	input wire logic rx_remote_i,
	input wire logic rx_extended_i,
	input wire logic tx_done_i,
	input wire logic [1:0] object_active_o,
	input wire logic [1:0] rx_store_o,
	input wire cma_pkg::cma_ident_t rx_store_id_o,
	input wire logic tx_start_o,
	input wire logic tx_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_read_idle_zero: assert property (!$past(rd_i) |-> rd_data_o == 32'h0) else $error("read data outside read");
	a_reserved_zero: assert property (rd_data_o[31:16] == 16'h0) else $error("reserved bits not zero");
	a_valid_follows: assert property (wr_i && addr_i == 8'h34 |->
		##2 object_active_o[0] == $past(wr_data_i[15], 2)) else $error("active flag wrong");
	a_set_isolated: assert property (wr_i && addr_i == 8'h34 |-> ##2 $stable(object_active_o[1]))
		else $error("other set changed");
	a_store_data_only: assert property (rx_store_o != 2'h0 |-> $past(rx_valid_i) && !$past(rx_remote_i))
		else $error("store without data frame");
	a_store_std_id: assert property (rx_store_o != 2'h0 && !$past(rx_extended_i) |->
		rx_store_id_o[17:0] == 18'h0) else $error("standard id low bits set");
	a_store_needs_valid: assert property ((rx_store_o & ~object_active_o) == 2'h0)
		else $error("store into invalid object");
	a_start_one_pulse: assert property (tx_start_o |=> !tx_start_o) else $error("start too long");
	a_start_when_idle: assert property (tx_start_o |-> tx_busy_o && !$past(tx_busy_o)) else $error("start while busy");
	a_done_frees: assert property (tx_busy_o && tx_done_i |=> !tx_busy_o || tx_start_o) else $error("busy after done");
endmodule : cma_top_monitor
bind cma_top cma_top_monitor cma_top_monitor_i (
	.clk_i(clk_i),
	.reset_i(reset_i),
	.addr_i(addr_i),
	.wr_data_i(wr_data_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rd_data_o(rd_data_o),
	.rx_valid_i(rx_valid_i),
	.rx_remote_i(rx_remote_i),
	.rx_extended_i(rx_extended_i),
	.tx_done_i(tx_done_i),
	.object_active_o(object_active_o),
	.rx_store_o(rx_store_o),
	.rx_store_id_o(rx_store_id_o),
	.tx_start_o(tx_start_o),
	.tx_busy_o(tx_busy_o)
);

// >>> tb/can_msg_object_arbitration_bench.sv
// bench of the arbitration block with a reference model
`timescale 1ns/1ps
module can_msg_object_arbitration_bench;
	import cma_pkg::*;
	logic clk_i = 1'h0, reset_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, rx_valid_i = 1'h0, rx_remote_i = 1'h0;
	logic rx_extended_i = 1'h0, tx_done_i, tx_start_o, tx_remote_o, tx_extended_o, tx_busy_o;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] ofs [5] = '{8'h34, 8'h94, 8'h3C, 8'h9C, 8'h40};
	logic [31:0] wr_data_i = 32'h0, rd_data_o;
	logic [15:0] if1_id_low_i = 16'h0, if2_id_low_i = 16'h0, lo, lo2;
	logic [15:0] m [2] = '{16'h0, 16'h0};
	logic [12:0] hi;
	logic [1:0] object_active_o, rx_store_o;
	cma_ident_t rx_id_i = 29'h0, rx_store_id_o, tx_id_o, id;
	int error_cnt = 0, num_checks = 0, n;
	cma_top cma_top_i (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.addr_i(addr_i),
		.wr_data_i(wr_data_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rd_data_o(rd_data_o),
		.if1_id_low_i(if1_id_low_i),
		.if2_id_low_i(if2_id_low_i),
		.rx_valid_i(rx_valid_i),
		.rx_remote_i(rx_remote_i),
		.rx_extended_i(rx_extended_i),
		.rx_id_i(rx_id_i),
		.tx_done_i(tx_done_i),
		.object_active_o(object_active_o),
		.rx_store_o(rx_store_o),
		.rx_store_id_o(rx_store_id_o),
		.tx_start_o(tx_start_o),
		.tx_remote_o(tx_remote_o),
		.tx_extended_o(tx_extended_o),
		.tx_id_o(tx_id_o),
		.tx_busy_o(tx_busy_o)
	);
	cma_node_model cma_node_model_i (.clk_i(clk_i), .tx_start_i(tx_start_o), .tx_done_o(tx_done_i));
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'h1;
		if (a == 8'h34) m[0] = d[15:0];
		if (a == 8'h94) m[1] = d[15:0];
		@(posedge clk_i);
		wr_i <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'h1;
		@(posedge clk_i);
		rd_i <= 1'h0;
		#1 chk(rd_data_o, e);
	endtask : rd
	task rx(input logic r, input logic x, input logic [1:0] e);
		@(posedge clk_i);
		rx_valid_i <= 1'h1;
		rx_remote_i <= r;
		rx_extended_i <= x;
		rx_id_i <= id;
		@(posedge clk_i);
		rx_valid_i <= 1'h0;
		#1 chk({30'h0, rx_store_o}, {30'h0, e});
	endtask : rx
	task idle;
		for (n = 0; n < 20 && tx_busy_o !== 1'h0; n++) begin
			@(posedge clk_i);
			#1;
		end
		chk({31'h0, tx_busy_o}, 32'h0);
	endtask : idle
	task wait_start;
		for (n = 0; n < 4 && tx_start_o !== 1'h1; n++) begin
			@(posedge clk_i);
			#1;
		end
	endtask : wait_start
	task end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	initial forever #50 clk_i = ~clk_i;
	initial begin
		#500000;
		error_cnt++;
		end_of_test;
	end
	initial begin
		void'($urandom(97939));
		repeat (12) @(posedge clk_i);
		reset_i <= 1'h0;
		foreach (ofs[k]) rd(ofs[k], 32'h0);
		wr(8'h34, $urandom & 32'h00007FFF);
		wr(8'h94, $urandom & 32'h00007FFF);
		rd(8'h34, {16'h0, m[0]});
		rd(8'h94, {16'h0, m[1]});
		hi = 13'($urandom);
		lo = 16'($urandom);
		lo2 = 16'($urandom);
		id = {hi, lo};
		wr(8'h94, 32'h0);
		if1_id_low_i <= lo;
		if2_id_low_i <= lo2;
		wr(8'h34, {16'h0, 3'h4, hi});
		rx(1'h0, 1'h0, 2'h1);
		chk({3'h0, rx_store_id_o}, {3'h0, id[28:18], 18'h0});
		chk({30'h0, object_active_o}, {30'h0, m[1][15], m[0][15]});
		rx(1'h0, 1'h1, 2'h0);
		rx(1'h1, 1'h0, 2'h0);
		wr(8'h34, 32'h0);
		rx(1'h0, 1'h0, 2'h0);
		for (int d = 1; d >= 0; d--) begin
			wr(8'h34, 32'h0);
			wr(8'h34, {16'h0, 2'h3, d[0], hi});
			wr(8'h3C, 32'h2);
			wait_start;
			chk({tx_start_o, tx_remote_o, tx_extended_o, tx_id_o}, {1'h1, !d[0], 1'h1, hi, lo});
			idle;
			rd(8'h3C, 32'h0);
		end
		wr(8'h34, 32'h0);
		wr(8'h34, {16'h0, 3'h7, hi});
		wr(8'h3C, 32'h1);
		rx(1'h1, 1'h1, 2'h0);
		rd(8'h3C, 32'h3);
		idle;
		rd(8'h3C, 32'h1);
		wr(8'h34, 32'h0);
		wr(8'h94, {16'h0, 3'h4, hi});
		wr(8'h9C, 32'h2);
		wait_start;
		chk({tx_start_o, tx_remote_o, tx_extended_o, tx_id_o}, {3'h6, hi, lo2});
		idle;
		rd(8'h9C, 32'h0);
		rd(8'h3C, 32'h1);
		end_of_test;
	end
endmodule : can_msg_object_arbitration_bench
